//--- rtl/rf_reader_config_registers.sv
// Purpose: Configuration and status register bank of a proximity-card reader.
// Assumes: Register commands arrive already decoded from the serial slave on ref_clk_i.
// Notes:   Only defined fields are stored, so reserved bits always read as zero.
// How it works
// - Sixteen byte registers decode at addresses 0x00 through 0x0F.
// - Five 16-bit protocol registers, low byte even address, high byte odd.
// - High byte bits 7..4 hold the frame wait exponent; 3..0 reserved.
// - Protocol register zero is read-only with fixed default settings.
// - Polling always takes its frame wait from protocol register zero.
// - Transmit commands use the protocol register one to four they select.
// - Status reads field on, power-up and card flag in bits 7..5.
// - Error register holds six error flags in bits 7..2.
// - Revision register returns a fixed design identifier.
// - Receiver configuration is read/write and drives the demodulator.
// - Transmitter configuration: bit 7 power, low field modulation level.
// - Clock-output register: standby bits 7..6, enable bit 5, rate bits 1..0.
// - Status, error, revision, protocol zero read-only; the rest read/write.
// - Clear resets writable registers and aborts the command through clear_abort_o.
// - Read register command 0x07, write register command 0x06.
`timescale 1ns/1ps
module rf_reader_config_registers #(
   parameter logic [7:0] REVISION_ID = 8'h5A,  // Arbitrary value.
   parameter logic [3:0] DEFAULT_FWE = 4'h4
) (
   // Clock and resets.
   input  wire logic       ref_clk_i,
   input  wire logic       srst_i,
   input  wire logic       reset_n_i,
   // Register command port.
   input  wire logic       cmd_valid_i,
   input  wire logic [7:0] cmd_code_i,
   input  wire logic [3:0] cmd_addr_i,
   input  wire logic [7:0] cmd_wdata_i,
   output logic      [7:0] rd_data_o,
   output logic            rd_valid_o,
   output logic            clear_abort_o,
   // Live status from the reader core.
   input  wire logic       carrier_field_on_i,
   input  wire logic       power_up_i,
   input  wire logic       card_detected_i,
   input  wire logic       rx_done_i,
   input  wire logic [5:0] rx_error_i,
   // Protocol selection from the command engine.
   input  wire logic       poll_active_i,
   input  wire logic [2:0] proto_sel_i,
   output logic      [3:0] frame_wait_exponent_o,
   // Configuration outputs.
   output logic            standby_ctrl_hi_o,
   output logic            standby_ctrl_lo_o,
   output logic            clock_out_enable_o,
   output logic      [1:0] clock_out_rate_sel_o,
   output logic            transmit_power_level_o,
   output logic      [6:0] modulation_level_o,
   output logic      [7:0] receiver_config_o
);

   // Register state.
   logic [4:1][7:0] proto_lo;
   logic [4:1][3:0] proto_fwe;
   logic [7:0]      clk_ctrl;
   logic [7:0]      tx_cfg;
   logic [7:0]      rx_cfg;
   logic [5:0]      err_flags;
   logic [3:0]      fwe_q;
   logic            rstn_meta;
   logic            rstn_sync;
   logic            rst;
   logic [7:0]      read_value;
   logic [4:1][7:0] next_proto_lo;
   logic [4:1][3:0] next_proto_fwe;
   logic [7:0]      next_clk_ctrl;
   logic [7:0]      next_tx_cfg;
   logic [7:0]      next_rx_cfg;
   logic [5:0]      next_err_flags;
   logic [3:0]      next_fwe_q;
   logic [7:0]      next_rd_data;
   logic            next_rd_valid;
   logic            next_clear;
   logic [2:0]      wr_idx;
   logic            is_wr;
   logic            is_rd;
   logic            is_clr;

   // The reset pin is asynchronous to ref_clk_i, so it passes two flops first.
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         rstn_meta <= 1'b0;
         rstn_sync <= 1'b0;
      end else begin
         rstn_meta <= reset_n_i;
         rstn_sync <= rstn_meta;
      end
   end

   assign rst    = srst_i | ~rstn_sync;
   assign is_wr  = cmd_valid_i && (cmd_code_i == rfreg_pkg::CMD_WRITE_REG);
   assign is_rd  = cmd_valid_i && (cmd_code_i == rfreg_pkg::CMD_READ_REG);
   assign is_clr = cmd_valid_i && (cmd_code_i == rfreg_pkg::CMD_CLEAR);
   assign wr_idx = cmd_addr_i[3:1];

   // Read multiplexer; all sixteen addresses decode, so no address goes unanswered.
   always_comb begin
      read_value = 8'h00;
      if (cmd_addr_i <= rfreg_pkg::PROTO_FOUR_HI) begin
         if (wr_idx == 3'h0) begin
            read_value = cmd_addr_i[0] ? {DEFAULT_FWE, 4'h0} : 8'h00;
         end else if (cmd_addr_i[0]) begin
            read_value = {proto_fwe[wr_idx], 4'h0};
         end else begin
            read_value = proto_lo[wr_idx];
         end
      end else begin
         case (cmd_addr_i)
            rfreg_pkg::DEVICE_STATUS: begin
               read_value[rfreg_pkg::STAT_FIELD_BIT] = carrier_field_on_i;
               read_value[rfreg_pkg::STAT_POWER_BIT] = power_up_i;
               read_value[rfreg_pkg::STAT_CARD_BIT]  = card_detected_i;
            end
            rfreg_pkg::LINK_ERROR_FLAGS: begin
               read_value[rfreg_pkg::ERR_MSB:rfreg_pkg::ERR_LSB] = err_flags;
            end
            rfreg_pkg::HARDWARE_REVISION:      read_value = REVISION_ID;
            rfreg_pkg::CLOCK_OUT_STANDBY_CTRL: read_value = clk_ctrl;
            rfreg_pkg::TRANSMITTER_CONFIG:     read_value = tx_cfg;
            rfreg_pkg::RECEIVER_CONFIG:        read_value = rx_cfg;
            default:                           read_value = 8'h00;
         endcase
      end
   end

   // Next-state logic for the whole bank.
   always_comb begin
      next_proto_lo  = proto_lo;
      next_proto_fwe = proto_fwe;
      next_clk_ctrl  = clk_ctrl;
      next_tx_cfg    = tx_cfg;
      next_rx_cfg    = rx_cfg;
      next_err_flags = err_flags;
      next_rd_data   = rd_data_o;
      next_rd_valid  = 1'b0;
      next_clear     = 1'b0;
      // Polling has priority: it never looks at the selectable registers.
      if (poll_active_i) begin
         next_fwe_q = DEFAULT_FWE;
      end else if (proto_sel_i >= rfreg_pkg::SEL_FIRST && proto_sel_i <= rfreg_pkg::SEL_LAST) begin
         next_fwe_q = proto_fwe[proto_sel_i[1:0] == 2'b00 ? 3'h4 : proto_sel_i];
      end else begin
         next_fwe_q = DEFAULT_FWE;
      end
      if (rx_done_i) begin
         next_err_flags = rx_error_i;
      end
      if (is_rd) begin
         next_rd_data  = read_value;
         next_rd_valid = 1'b1;
      end
      if (is_clr) begin
         next_proto_lo  = {4{rfreg_pkg::PROTO_LO_RST}};
         next_proto_fwe = {4{rfreg_pkg::PROTO_HI_RST}};
         next_clk_ctrl  = rfreg_pkg::CLKCTRL_RST;
         next_tx_cfg    = rfreg_pkg::TX_RST;
         next_rx_cfg    = rfreg_pkg::RX_RST;
         next_clear     = 1'b1;
      end else if (is_wr) begin
         // Only defined fields are kept; reserved bits are dropped on write.
         if (cmd_addr_i <= rfreg_pkg::PROTO_FOUR_HI && wr_idx != 3'h0) begin
            if (cmd_addr_i[0]) begin
               next_proto_fwe[wr_idx] =
                  cmd_wdata_i[rfreg_pkg::FWE_MSB:rfreg_pkg::FWE_LSB];
            end else begin
               next_proto_lo[wr_idx] = cmd_wdata_i;
            end
         end else begin
            case (cmd_addr_i)
               rfreg_pkg::CLOCK_OUT_STANDBY_CTRL: begin
                  next_clk_ctrl = {cmd_wdata_i[rfreg_pkg::STBY_HI_BIT:rfreg_pkg::CLK_EN_BIT],
                                   3'b000,
                                   cmd_wdata_i[rfreg_pkg::RATE_MSB:rfreg_pkg::RATE_LSB]};
               end
               rfreg_pkg::TRANSMITTER_CONFIG: next_tx_cfg = cmd_wdata_i;
               rfreg_pkg::RECEIVER_CONFIG:    next_rx_cfg = cmd_wdata_i;
               default:                       ;
            endcase
         end
      end
   end

   // State registers.
   always_ff @(posedge ref_clk_i) begin
      if (rst) begin
         proto_lo      <= {4{rfreg_pkg::PROTO_LO_RST}};
         proto_fwe     <= {4{rfreg_pkg::PROTO_HI_RST}};
         clk_ctrl      <= rfreg_pkg::CLKCTRL_RST;
         tx_cfg        <= rfreg_pkg::TX_RST;
         rx_cfg        <= rfreg_pkg::RX_RST;
         err_flags     <= rfreg_pkg::ERR_RST;
         fwe_q         <= 4'h0;
         rd_data_o     <= 8'h00;
         rd_valid_o    <= 1'b0;
         clear_abort_o <= 1'b0;
      end else begin
         proto_lo      <= next_proto_lo;
         proto_fwe     <= next_proto_fwe;
         clk_ctrl      <= next_clk_ctrl;
         tx_cfg        <= next_tx_cfg;
         rx_cfg        <= next_rx_cfg;
         err_flags     <= next_err_flags;
         fwe_q         <= next_fwe_q;
         rd_data_o     <= next_rd_data;
         rd_valid_o    <= next_rd_valid;
         clear_abort_o <= next_clear;
      end
   end

   // Configuration fields straight from their registers.
   assign frame_wait_exponent_o  = fwe_q;
   assign standby_ctrl_hi_o      = clk_ctrl[rfreg_pkg::STBY_HI_BIT];
   assign standby_ctrl_lo_o      = clk_ctrl[rfreg_pkg::STBY_LO_BIT];
   assign clock_out_enable_o     = clk_ctrl[rfreg_pkg::CLK_EN_BIT];
   assign clock_out_rate_sel_o   = clk_ctrl[rfreg_pkg::RATE_MSB:rfreg_pkg::RATE_LSB];
   assign transmit_power_level_o = tx_cfg[rfreg_pkg::TX_POWER_BIT];
   assign modulation_level_o     = tx_cfg[rfreg_pkg::MOD_MSB:rfreg_pkg::MOD_LSB];
   assign receiver_config_o      = rx_cfg;

   // Checks on the bank's own behaviour.
   a_read_answer: assert property (@(posedge ref_clk_i) disable iff (rst)
      is_rd |=> rd_valid_o && rd_data_o == $past(read_value))
      else $error("Read answer missing or wrong.");
   a_default_fixed: assert property (@(posedge ref_clk_i) disable iff (rst)
      is_rd && cmd_addr_i == rfreg_pkg::PROTO_DEFAULT_HI |=> rd_data_o == {DEFAULT_FWE, 4'h0})
      else $error("Default protocol register altered.");
   a_poll_default: assert property (@(posedge ref_clk_i) disable iff (rst)
      poll_active_i |=> frame_wait_exponent_o == DEFAULT_FWE)
      else $error("Polling used a selectable register.");
   a_sel_fwe: assert property (@(posedge ref_clk_i) disable iff (rst)
      !poll_active_i && proto_sel_i == 3'h2 |=> frame_wait_exponent_o == $past(proto_fwe[2]))
      else $error("Selected frame wait not applied.");
   a_tx_write: assert property (@(posedge ref_clk_i) disable iff (rst)
      is_wr && !is_clr && cmd_addr_i == rfreg_pkg::TRANSMITTER_CONFIG
      |=> tx_cfg == $past(cmd_wdata_i))
      else $error("Transmitter write lost.");
   a_clear_all: assert property (@(posedge ref_clk_i) disable iff (rst)
      is_clr |=> clear_abort_o && tx_cfg == rfreg_pkg::TX_RST && rx_cfg == rfreg_pkg::RX_RST
              && clk_ctrl == rfreg_pkg::CLKCTRL_RST ##1 (!clear_abort_o || $past(is_clr)))
      else $error("Clear did not reset the bank.");
   a_ro_ignored: assert property (@(posedge ref_clk_i) disable iff (rst)
      is_wr && cmd_addr_i >= rfreg_pkg::DEVICE_STATUS && cmd_addr_i <= rfreg_pkg::HARDWARE_REVISION
      |=> $stable(proto_fwe) && $stable(proto_lo) && $stable(tx_cfg) && $stable(rx_cfg))
      else $error("Read-only write changed state.");
   a_err_update: assert property (@(posedge ref_clk_i) disable iff (rst)
      rx_done_i ##1 is_rd && cmd_addr_i == rfreg_pkg::LINK_ERROR_FLAGS
      |=> rd_data_o == {$past(rx_error_i, 2), 2'b00})
      else $error("Error flags not updated.");
   a_status_bits: assert property (@(posedge ref_clk_i) disable iff (rst)
      is_rd && cmd_addr_i == rfreg_pkg::DEVICE_STATUS
      |=> rd_data_o[4:0] == 5'h00 && rd_data_o[7] == $past(carrier_field_on_i))
      else $error("Status read wrong.");

endmodule : rf_reader_config_registers

//--- inc/rfreg_pkg.sv
// Purpose: Shared constants for the reader configuration and status register bank.
// Assumes: Byte-wide registers at sixteen consecutive addresses.
// Notes:   All offsets, field positions, command codes and reset values live here.
package rfreg_pkg;

   // Bus widths.
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam int SEL_W  = 3;

   // Register offsets.
   localparam logic [3:0] PROTO_DEFAULT_LO       = 4'h0;
   localparam logic [3:0] PROTO_DEFAULT_HI       = 4'h1;
   localparam logic [3:0] PROTO_FOUR_HI          = 4'h9;
   localparam logic [3:0] DEVICE_STATUS          = 4'hA;
   localparam logic [3:0] LINK_ERROR_FLAGS       = 4'hB;
   localparam logic [3:0] HARDWARE_REVISION      = 4'hC;
   localparam logic [3:0] CLOCK_OUT_STANDBY_CTRL = 4'hD;
   localparam logic [3:0] TRANSMITTER_CONFIG     = 4'hE;
   localparam logic [3:0] RECEIVER_CONFIG        = 4'hF;

   // Command codes decoded by the bank.
   localparam logic [7:0] CMD_WRITE_REG = 8'h06;
   localparam logic [7:0] CMD_READ_REG  = 8'h07;
   localparam logic [7:0] CMD_CLEAR     = 8'h0E;

   // Protocol register selector values used by transmit commands.
   localparam logic [2:0] SEL_FIRST = 3'h1;
   localparam logic [2:0] SEL_LAST  = 3'h4;

   // Field positions.
   localparam int FWE_MSB        = 7;
   localparam int FWE_LSB        = 4;
   localparam int FWE_W          = 4;
   localparam int STAT_FIELD_BIT = 7;
   localparam int STAT_POWER_BIT = 6;
   localparam int STAT_CARD_BIT  = 5;
   localparam int ERR_MSB        = 7;
   localparam int ERR_LSB        = 2;
   localparam int ERR_W          = 6;
   localparam int STBY_HI_BIT    = 7;
   localparam int STBY_LO_BIT    = 6;
   localparam int CLK_EN_BIT     = 5;
   localparam int RATE_MSB       = 1;
   localparam int RATE_LSB       = 0;
   localparam int TX_POWER_BIT   = 7;
   localparam int MOD_MSB        = 6;
   localparam int MOD_LSB        = 0;

   // Reset values of the writable state.
   localparam logic [7:0] PROTO_LO_RST = 8'h00;
   localparam logic [3:0] PROTO_HI_RST = 4'h0;
   localparam logic [7:0] CLKCTRL_RST  = 8'h00;
   localparam logic [7:0] TX_RST       = 8'h00;
   localparam logic [7:0] RX_RST       = 8'h00;
   localparam logic [5:0] ERR_RST      = 6'h00;

endpackage : rfreg_pkg

//--- bench/host_model.sv
// Purpose: Host model that issues register commands to the bank.
// Assumes: Commands launch on the falling edge as a one-cycle strobe.
// Notes:   Released qualifiers show inverted values so stale data never looks valid.
`timescale 1ns/1ps
module host_model (
   // Clock.
   input  wire logic       ref_clk_i,
   // Command port towards the bank.
   output logic            cmd_valid_o,
   output logic      [7:0] cmd_code_o,
   output logic      [3:0] cmd_addr_o,
   output logic      [7:0] cmd_wdata_o,
   // Read answer from the bank.
   input  wire logic [7:0] rd_data_i,
   input  wire logic       rd_valid_i
);
   // Idle values at time zero.
   initial begin
      cmd_valid_o = 1'b0;
      cmd_code_o  = 8'h00;
      cmd_addr_o  = 4'h0;
      cmd_wdata_o = 8'h00;
   end

   // One strobe; the 4-bit address cannot leave the sixteen locations.
   task automatic issue(input logic [7:0] code, input logic [3:0] addr,
                        input logic [7:0] data);
      @(negedge ref_clk_i);
      cmd_valid_o = 1'b1;
      cmd_code_o  = code;
      cmd_addr_o  = addr;
      cmd_wdata_o = data;
      @(negedge ref_clk_i);
      cmd_valid_o = 1'b0;
      cmd_code_o  = ~code;
      cmd_addr_o  = ~addr;
      cmd_wdata_o = ~data;
   endtask : issue

   // Callers keep reserved bits and protocol low bytes at zero.
   task automatic write_reg(input logic [3:0] addr, input logic [7:0] data);
      issue(rfreg_pkg::CMD_WRITE_REG, addr, data);
   endtask : write_reg

   // The answer stands for one cycle, so it is taken right after the strobe.
   task automatic read_reg(input logic [3:0] addr, output logic [7:0] data,
                           output logic ok);
      issue(rfreg_pkg::CMD_READ_REG, addr, 8'h00);
      data = rd_data_i;
      ok   = rd_valid_i;
   endtask : read_reg
endmodule : host_model

//--- bench/rf_reader_config_registers_tb_top.sv
// Purpose: Self-checking bench for the register bank.
// Assumes: Inputs change on the falling edge; host model issues commands.
// Notes:   Table rows cover plain accesses; resets and side effects follow by hand.
`timescale 1ns/1ps
module rf_reader_config_registers_tb_top;
   localparam logic [7:0] REV = 8'h3C;  // Arbitrary value.
   localparam logic [3:0] FWD = 4'h4;
   typedef struct packed {logic [3:0] a; logic [7:0] w; logic [7:0] e;} row_s;
   logic ref_clk_i = 1'b0, srst_i = 1'b1, reset_n_i = 1'b1;
   logic cmd_valid, rd_valid, clr, fon = 1'b0, pwr = 1'b0, card = 1'b0;
   logic rx_done = 1'b0, poll = 1'b0, shi, slo, cen, transmit_power_level;
   logic [7:0] cmd_code, cmd_wdata, rd_data, receiver_config, got;
   logic [3:0] cmd_addr, fwe;
   logic [5:0] rx_err = 6'h00;
   logic [2:0] sel = 3'h0;
   logic [1:0] rate;
   logic [6:0] mod;
   logic       ok;
   int         failures = 0, num_checks = 0, cycles = 0;
   row_s rows [11] = '{'{4'h3, 8'h30, 8'h30}, '{4'h5, 8'h50, 8'h50}, '{4'h7, 8'h70, 8'h70},
      '{4'h9, 8'h90, 8'h90}, '{4'h2, 8'h00, 8'h00}, '{4'hD, 8'hE2, 8'hE2},
      '{4'hF, 8'hC3, 8'hC3}, '{4'hE, 8'h85, 8'h85}, '{4'h1, 8'hF0, {FWD, 4'h0}},
      '{4'h0, 8'h00, 8'h00}, '{4'hC, 8'hFF, REV}};

   always #25 ref_clk_i = ~ref_clk_i;

   host_model host (.ref_clk_i(ref_clk_i), .cmd_valid_o(cmd_valid), .cmd_code_o(cmd_code),
      .cmd_addr_o(cmd_addr), .cmd_wdata_o(cmd_wdata), .rd_data_i(rd_data),
      .rd_valid_i(rd_valid));

   rf_reader_config_registers #(.REVISION_ID(REV), .DEFAULT_FWE(FWD)) dut (
      .ref_clk_i(ref_clk_i), .srst_i(srst_i), .reset_n_i(reset_n_i),
      .cmd_valid_i(cmd_valid), .cmd_code_i(cmd_code), .cmd_addr_i(cmd_addr),
      .cmd_wdata_i(cmd_wdata), .rd_data_o(rd_data), .rd_valid_o(rd_valid),
      .clear_abort_o(clr), .carrier_field_on_i(fon), .power_up_i(pwr),
      .card_detected_i(card), .rx_done_i(rx_done), .rx_error_i(rx_err),
      .poll_active_i(poll), .proto_sel_i(sel), .frame_wait_exponent_o(fwe),
      .standby_ctrl_hi_o(shi), .standby_ctrl_lo_o(slo), .clock_out_enable_o(cen),
      .clock_out_rate_sel_o(rate), .transmit_power_level_o(transmit_power_level),
      .modulation_level_o(mod), .receiver_config_o(receiver_config));

   // Counts and verdict; the single place where the run ends.
   task automatic finish_test();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : finish_test

   // One compare of a byte against its expected value.
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      num_checks++;
      if (g !== e) begin
         failures++;
         $display("BAD %0t got %h expected %h", $time, g, e);
      end
   endtask : chk

   // Read a register and demand a valid answer with the expected byte.
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
      host.read_reg(a, got, ok);
      chk({7'h00, ok}, 8'h01);
      chk(got, e);
   endtask : rd_chk

   // Hang guard; the whole run needs well under a thousand cycles.
   always @(posedge ref_clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         failures++;
         finish_test();
      end
   end

   initial begin
      repeat (10) @(negedge ref_clk_i);
      srst_i = 1'b0;
      // The reset pin synchroniser was cleared too, so the bank stays in reset two more edges.
      repeat (2) @(negedge ref_clk_i);
      foreach (rows[i]) host.write_reg(rows[i].a, rows[i].w);
      foreach (rows[i]) rd_chk(rows[i].a, rows[i].e);
      chk({shi, slo, cen, 3'h0, rate}, 8'hE2);
      chk({transmit_power_level, mod}, 8'h85);
      chk(receiver_config, 8'hC3);
      $display("test table done");
      // Each selector picks its own exponent; selector zero and bad selectors use the default.
      for (int s = 0; s < 8; s++) begin
         @(negedge ref_clk_i);
         sel = s[2:0];
         @(negedge ref_clk_i);
         chk({4'h0, fwe}, (s >= 1 && s <= 4) ? 8'(2 * s + 1) : 8'(FWD));
      end
      // Polling overrides a valid selector, so the default comes back with selector two still applied.
      sel = 3'h2;
      poll = 1'b1;
      @(negedge ref_clk_i);
      @(negedge ref_clk_i);
      chk({4'h0, fwe}, 8'(FWD));
      poll = 1'b0;
      $display("test frame wait done");
      fon = 1'b1;
      pwr = 1'b1;
      card = 1'b1;
      rd_chk(4'hA, 8'hE0);
      fon = 1'b0;
      card = 1'b0;
      rd_chk(4'hA, 8'h40);
      rx_err = 6'h2D;
      rx_done = 1'b1;
      // The read follows the capture edge at once, so the back-to-back path is exercised.
      fork
         rd_chk(4'hB, 8'hB4);
         begin
            @(negedge ref_clk_i);
            rx_done = 1'b0;
            rx_err = 6'h12;
         end
      join
      $display("test status done");
      host.issue(rfreg_pkg::CMD_CLEAR, 4'h0, 8'h00);
      chk({7'h00, clr}, 8'h01);
      rd_chk(4'hE, 8'h00);
      rd_chk(4'h3, 8'h00);
      rd_chk(4'h1, {FWD, 4'h0});
      rd_chk(4'hB, 8'hB4);
      $display("test clear done");
      host.write_reg(4'hF, 8'h5A);
      srst_i = 1'b1;
      @(negedge ref_clk_i);
      srst_i = 1'b0;
      repeat (2) @(negedge ref_clk_i);
      rd_chk(4'hF, 8'h00);
      host.write_reg(4'hF, 8'h5A);
      reset_n_i = 1'b0;
      repeat (3) @(negedge ref_clk_i);
      chk(receiver_config, 8'h00);
      reset_n_i = 1'b1;
      repeat (3) @(negedge ref_clk_i);
      rd_chk(4'h5, 8'h00);
      $display("test reset done");
      finish_test();
   end
endmodule : rf_reader_config_registers_tb_top
